// file: rtl/scs_defines.svh
// Timing counts and code constants for the conversion sequencer.
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
`define SCS_NBITS        16
`define SCS_CLK_NS       10
`define SCS_MIN_PERIOD_NS 2000
`define SCS_MIN_PERIOD_CYC ((`SCS_MIN_PERIOD_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_SETTLE_CYC   4'h2
`define SCS_CODE_MAX     16'h7fff
`define SCS_CODE_MIN     16'h8000
`define SCS_BIT_MSB      4'hf
`endif

// file: rtl/scs_pkg.sv
// Types shared by the conversion sequencer.
package scs_pkg;
  typedef enum logic [2:0] {
    SCS_ACQ,
    SCS_OPEN_SW,
    SCS_GROUND_ARR,
    SCS_TRIAL,
    SCS_SETTLE,
    SCS_CODE
  } scs_state_t;
endpackage

// file: rtl/scs_sar_sequencer.sv
// Successive-approximation conversion sequencer for a 16-bit differential converter.
// Overview of operation
// - Rising convert_start after acquisition ends acquisition and starts conversion.
// - Conversion opens both ground switches first, then grounds both arrays.
// - In acquisition comparator terminals are grounded, array switches on inputs.
// - Two matched 16-element binary-weighted arrays step by halving weights.
// - Trials run MSB first to LSB, each element to ground or reference.
// - After the trials return to acquisition, form the code, give busy.
// - Conversions are timed by the internal clock; no serial clock needed.
// - Result belongs to the conversion just done; at most 500 kSPS.
// - Conversion circuitry is powered down between conversions.
// - Output is 16-bit two's complement centred on zero.
// - Overrange or top input saturates to 0x7fff.
// - Underrange without overrange, or bottom input, saturates to 0x8000.
`include "scs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module scs_sar_sequencer
  import scs_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Host start pin.
  input  wire logic        convert_start,
  // Analog front end.
  input  wire logic        comp_out,
  input  wire logic        over_range,
  input  wire logic        under_range,
  output logic             pos_ground_switch,
  output logic             neg_ground_switch,
  output logic             array_on_inputs,
  output logic [15:0]      array_to_ref,
  output logic             analog_power_on,
  // Result.
  output logic [15:0]      result_code,
  output logic             result_valid,
  output logic             busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detector.

  logic       start_s1_q;
  logic       start_s2_q;
  logic       start_s3_q;
  logic       comp_s1_q;
  logic       comp_s2_q;
  logic [1:0] rng_s1_q;
  logic [1:0] rng_s2_q;
  logic       start_rise;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_s1_q <= 1'b0;
      start_s2_q <= 1'b0;
      start_s3_q <= 1'b0;
      comp_s1_q  <= 1'b0;
      comp_s2_q  <= 1'b0;
      rng_s1_q   <= 2'h0;
      rng_s2_q   <= 2'h0;
    end else begin
      start_s1_q <= convert_start;
      start_s2_q <= start_s1_q;
      start_s3_q <= start_s2_q;
      comp_s1_q  <= comp_out;
      comp_s2_q  <= comp_s1_q;
      rng_s1_q   <= {over_range, under_range};
      rng_s2_q   <= rng_s1_q;
    end
  end

  // The third stage feeds only the edge detector; the first stage feeds only the second.
  assign start_rise = start_s2_q & ~start_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  scs_state_t  state_q;
  scs_state_t  state_d;
  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic [3:0]  wait_q;
  logic [3:0]  wait_d;
  logic [15:0] trial_q;
  logic [15:0] trial_d;
  logic [15:0] code_q;
  logic [15:0] code_d;
  logic        valid_q;
  logic        valid_d;
  logic [1:0]  rng_q;
  logic [1:0]  rng_d;
  logic [15:0] gap_q;
  logic [15:0] gap_d;

  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    wait_d  = wait_q;
    trial_d = trial_q;
    code_d  = code_q;
    valid_d = 1'b0;
    rng_d   = rng_q;
    gap_d   = (gap_q != 16'h0) ? gap_q - 16'h1 : gap_q;
    unique case (state_q)
      SCS_ACQ: begin
        // Starts closer than the minimum period are ignored to cap throughput.
        // The gap counter runs in every state, so spacing is measured start to start.
        if (start_rise && gap_q == 16'h0) begin
          state_d = SCS_OPEN_SW;
          gap_d   = 16'(`SCS_MIN_PERIOD_CYC - 1);
        end
      end
      SCS_OPEN_SW: begin
        state_d = SCS_GROUND_ARR;
        // Range flags are taken once, so a flag that moves mid-conversion cannot mix clamps.
        rng_d   = rng_s2_q;
      end
      SCS_GROUND_ARR: begin
        state_d = SCS_TRIAL;
        bit_d   = `SCS_BIT_MSB;
        trial_d = 16'h8000;
        wait_d  = `SCS_SETTLE_CYC;
      end
      SCS_TRIAL: begin
        // The comparator needs a few cycles to settle after each switch step.
        if (wait_q != 4'h0) begin
          wait_d = wait_q - 4'h1;
        end else begin
          state_d = SCS_SETTLE;
        end
      end
      SCS_SETTLE: begin
        // A high comparator means the trial weight overshot, so drop it.
        if (comp_s2_q) begin
          trial_d[bit_q] = 1'b0;
        end
        if (bit_q == 4'h0) begin
          state_d = SCS_CODE;
        end else begin
          trial_d[bit_q - 4'h1] = 1'b1;
          bit_d  = bit_q - 4'h1;
          wait_d = `SCS_SETTLE_CYC;
          state_d = SCS_TRIAL;
        end
      end
      SCS_CODE: begin
        // Offset binary to two's complement, with range clamps.
        // Overrange is tested first, so it wins if the front end raises both flags.
        if (rng_q[1]) begin
          code_d = `SCS_CODE_MAX;
        end else if (rng_q[0]) begin
          code_d = `SCS_CODE_MIN;
        end else begin
          code_d = {~trial_q[15], trial_q[14:0]};
        end
        valid_d = 1'b1;
        state_d = SCS_ACQ;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= SCS_ACQ;
      bit_q   <= 4'h0;
      wait_q  <= 4'h0;
      trial_q <= 16'h0;
      code_q  <= 16'h0;
      valid_q <= 1'b0;
      rng_q   <= 2'h0;
      gap_q   <= 16'h0;
    end else begin
      state_q <= state_d;
      bit_q   <= bit_d;
      wait_q  <= wait_d;
      trial_q <= trial_d;
      code_q  <= code_d;
      valid_q <= valid_d;
      rng_q   <= rng_d;
      gap_q   <= gap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Element switch drive.

  // Registered so that state decoding can never glitch an element onto the reference.
  logic [15:0] ref_q;
  logic [15:0] ref_d;

  always_comb begin
    ref_d = 16'h0;
    if (state_d == SCS_TRIAL || state_d == SCS_SETTLE) begin
      ref_d = trial_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ref_q <= 16'h0;
    end else begin
      ref_q <= ref_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all timed from sys_clk only.
  // The ground switches decode the state register, so they change only on a clock edge.

  logic acq;
  assign acq = (state_q == SCS_ACQ);

  assign pos_ground_switch = acq;
  assign neg_ground_switch = acq;
  assign array_on_inputs   = acq | (state_q == SCS_OPEN_SW);
  assign array_to_ref      = ref_q;
  assign analog_power_on   = ~acq;
  assign busy              = ~acq;
  assign result_code       = code_q;
  assign result_valid      = valid_q;

endmodule
`default_nettype wire

// file: verification/scs_host_model.sv
// Comparator stand-in for the sequencer's analog side.
`timescale 1ns/1ps
`default_nettype none
module scs_host_model (
  input  wire logic [15:0] array_to_ref,
  input  wire logic [15:0] level,
  output logic             comp_out
);
  // A 1 means the trial overshoots the held level, so the bit is dropped.
  assign comp_out = array_to_ref > level;
endmodule
`default_nettype wire

// file: verification/scs_sar_asserts.sv
// Port checks for the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module scs_sar_asserts (
  input wire logic        sys_clk, rst, convert_start, comp_out, over_range, under_range,
  input wire logic        pos_ground_switch, neg_ground_switch, array_on_inputs,
  input wire logic        analog_power_on, result_valid, busy,
  input wire logic [15:0] array_to_ref, result_code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_start_cause: assert property ($rose(busy) |-> convert_start)
    else $error("busy rose without a start");
  a_sw_open: assert property ($rose(busy) |-> !pos_ground_switch && !neg_ground_switch)
    else $error("ground switches still closed");
  a_arr_order: assert property ($rose(busy) |-> array_on_inputs ##1 !array_on_inputs)
    else $error("arrays left inputs out of order");
  a_acq_idle: assert property (!busy |-> pos_ground_switch && neg_ground_switch
    && array_on_inputs && array_to_ref == 16'h0000) else $error("acquisition state wrong");
  a_msb_first: assert property ($fell(array_on_inputs) |=> array_to_ref == 16'h8000)
    else $error("first trial not the top bit");
  a_conv_time: assert property ($rose(busy) |-> ##[60:75] result_valid)
    else $error("conversion did not finish in time");
  a_busy_done: assert property ($fell(busy) |-> result_valid)
    else $error("busy fell without a result");
  a_valid_pulse: assert property (result_valid |=> !result_valid)
    else $error("result pulse too long");
  a_code_hold: assert property (!result_valid |-> $stable(result_code))
    else $error("result changed between conversions");
  a_power_down: assert property (!busy |-> !analog_power_on)
    else $error("powered while idle");
  c_top: cover property (result_valid && result_code == 16'h7fff);
  c_bottom: cover property (result_valid && result_code == 16'h8000);
  c_zero: cover property (result_valid && result_code == 16'h0000);
endmodule
bind scs_sar_sequencer scs_sar_asserts i_chk (.sys_clk, .rst, .convert_start, .comp_out,
  .over_range, .under_range, .pos_ground_switch, .neg_ground_switch, .array_on_inputs,
  .analog_power_on, .result_valid, .busy, .array_to_ref, .result_code);
`default_nettype wire

// file: verification/scs_sar_sequencer_tb.sv
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR %0t %h %h", $time, a, e); end end
module scs_sar_sequencer_tb;
  logic        sys_clk = 1'b0, rst = 1'b1, convert_start = 1'b0;
  logic        over_range = 1'b0, under_range = 1'b0, comp_out, busy, result_valid;
  logic        pos_ground_switch, neg_ground_switch, array_on_inputs, analog_power_on;
  logic [15:0] array_to_ref, result_code, level = 16'h8000;
  int          err_total = 0, n_compared = 0;
  scs_host_model i_host (.array_to_ref, .level, .comp_out);
  scs_sar_sequencer i_dut (.sys_clk, .rst, .convert_start, .comp_out, .over_range,
    .under_range, .pos_ground_switch, .neg_ground_switch, .array_on_inputs, .array_to_ref,
    .analog_power_on, .result_code, .result_valid, .busy);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic end_sim;
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Spacing after each result keeps starts over 200 cycles apart, so none is refused.
  task automatic convert(input logic [15:0] lv, input logic ov, un, input logic [15:0] code);
    int n;
    @(posedge sys_clk) {level, over_range, under_range} <= {lv, ov, un};
    repeat (4) @(posedge sys_clk);
    convert_start <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 `CHK(busy, 1'b1)
    `CHK(analog_power_on, 1'b1)
    `CHK(pos_ground_switch | neg_ground_switch | array_on_inputs, 1'b0)
    n = 0;
    while (result_valid !== 1'b1 && n < 100) begin @(posedge sys_clk); #1; n++; end
    `CHK(result_valid, 1'b1)
    `CHK(result_code, code)
    `CHK(busy, 1'b0)
    `CHK(pos_ground_switch & neg_ground_switch & array_on_inputs, 1'b1)
    `CHK(array_to_ref, 16'h0000)
    `CHK(analog_power_on, 1'b0)
    @(posedge sys_clk) convert_start <= 1'b0;
    repeat (140) @(posedge sys_clk);
  endtask
  task automatic t_codes;
    convert(16'h8000, 1'b0, 1'b0, 16'h0000);
    convert(16'h8001, 1'b0, 1'b0, 16'h0001);
    convert(16'h7fff, 1'b0, 1'b0, 16'hffff);
    convert(16'h0001, 1'b0, 1'b0, 16'h8001);
  endtask
  task automatic t_top;
    convert(16'hffff, 1'b0, 1'b0, 16'h7fff);
    convert(16'h8000, 1'b1, 1'b0, 16'h7fff);
  endtask
  task automatic t_bottom;
    convert(16'h0000, 1'b0, 1'b0, 16'h8000);
    convert(16'h8000, 1'b0, 1'b1, 16'h8000);
  endtask
  // A second rise soon after a result must be ignored to hold the rate cap.
  task automatic t_spacing;
    @(posedge sys_clk) convert_start <= 1'b1;
    repeat (40) @(posedge sys_clk);
    #1 `CHK(busy, 1'b1)
    repeat (40) @(posedge sys_clk);
    convert_start <= 1'b0;
    @(posedge sys_clk) convert_start <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 `CHK(busy, 1'b0)
    @(posedge sys_clk) convert_start <= 1'b0;
    repeat (200) @(posedge sys_clk);
  endtask
  // Reset in mid-conversion must drop straight back to acquisition, with no false start.
  task automatic t_reset;
    @(posedge sys_clk) convert_start <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    {rst, convert_start} <= 2'b00;
    #1 `CHK(busy, 1'b0)
    `CHK(pos_ground_switch & neg_ground_switch & array_on_inputs, 1'b1)
    repeat (4) @(posedge sys_clk);
    #1 `CHK(busy, 1'b0)
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_codes();
    t_spacing();
    t_reset();
    t_top();
    t_bottom();
    end_sim();
  end
  initial begin
    #40000;
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire
